// *** rtl/amcr_regs.svh ***
`ifndef AMCR_REGS_SVH
`define AMCR_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define AMCR_OFF_MODE 8'h02
`define AMCR_OFF_TIMING 8'h03
`define AMCR_OFF_SETUP 8'h04
`define AMCR_OFF_ERRCLR 8'h07
// ----------------------------------------
// reset values
// ----------------------------------------
`define AMCR_RST_MODE 8'h0C
`define AMCR_RST_TIMING 8'h2B
`define AMCR_RST_SETUP 8'h4B
// ----------------------------------------
// writable masks
// ----------------------------------------
`define AMCR_MASK_MODE 8'h3F
`define AMCR_MASK_TIMING 8'h3F
// ----------------------------------------
// field positions
// ----------------------------------------
`define AMCR_EDGE_LSB 4
`define AMCR_OC_BIT 3
`define AMCR_OT_BIT 2
`define AMCR_R2B_BIT 1
`define AMCR_L2B_BIT 0
`define AMCR_REL_LSB 3
`define AMCR_ATK_LSB 0
`define AMCR_ALC_BIT 7
`define AMCR_COMP_LSB 5
`define AMCR_BASIS_BIT 4
`define AMCR_LVL_LSB 0
// ----------------------------------------
// step timing, 200 MHz clock
// ----------------------------------------
`define AMCR_CLK_MHZ 200
`define AMCR_REL_BASE_US 4000
`define AMCR_ATK_BASE_US 32
`define AMCR_REL_BASE_CYC (`AMCR_REL_BASE_US * `AMCR_CLK_MHZ)
`define AMCR_ATK_BASE_CYC (`AMCR_ATK_BASE_US * `AMCR_CLK_MHZ)
`endif

// *** rtl/amcr_pkg.sv ***
package amcr_pkg;
    typedef enum logic [1:0]
    {
        AMCR_EDGE_NORMAL = 2'b00,
        AMCR_EDGE_SLOW1 = 2'b01,
        AMCR_EDGE_SLOW2 = 2'b10,
        AMCR_EDGE_SLOW3 = 2'b11
    } amcr_edge_t;
    typedef enum logic [1:0]
    {
        AMCR_COMP_LIMIT = 2'b00,
        AMCR_COMP_CURVE1 = 2'b01,
        AMCR_COMP_CURVE2 = 2'b10,
        AMCR_COMP_CURVE3 = 2'b11
    } amcr_comp_t;
endpackage

// *** rtl/amcr_mode_level_regs.sv ***
`timescale 1ns/100ps
`include "amcr_regs.svh"
// Function
// RULE_01 - edge select 00 normal edges; 01, 10, 11 slow edges
// RULE_02 - separate overcurrent and overheat auto retry enables, default 1
// RULE_03 - right-to-both mix sends right input to both outputs, default 0
// RULE_04 - left-to-both mix sends left input to both outputs, default 0
// RULE_05 - release step 4 ms doubling to 512 ms, default code 101
// RULE_06 - attack step 32 us doubling to 4 ms, default code 011
// RULE_07 - auto level enable hands gain to level control, default 0
// RULE_08 - compressor select 00 limiter, 01..11 curves, default 10
// RULE_09 - threshold basis 0 tracks supply, 1 fixed power, default 0
// RULE_10 - four bit threshold level code, default 1011
// RULE_11 - gain code writes ignored while auto level is enabled
// RULE_12 - threshold codes map monotonically, 0000 lowest to 1111 highest
// RULE_13 - error clear write ends a latched fault when retry is off
// RULE_14 - unused upper mode and timing bits read zero, ignore writes
module amcr_mode_level_regs
#(
    // base step counts, overridable so a bench can shorten long intervals
    parameter int unsigned REL_BASE_CYC = `AMCR_REL_BASE_CYC,
    parameter int unsigned ATK_BASE_CYC = `AMCR_ATK_BASE_CYC
)
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output amcr_pkg::amcr_edge_t o_edge_select,
    output logic o_slow_edges,
    output logic o_overcurrent_auto_retry,
    output logic o_overheat_auto_retry,
    output logic o_right_to_both_mix,
    output logic o_left_to_both_mix,
    output logic [2:0] o_release_rate_select,
    output logic [2:0] o_attack_rate_select,
    output logic o_auto_level_enable,
    output amcr_pkg::amcr_comp_t o_compressor_select,
    output logic o_threshold_basis_select,
    output logic [3:0] o_level_threshold_code,
    output logic o_gain_write_allow,
    output logic o_error_clear,
    output logic o_release_step,
    output logic o_attack_step
);
    import amcr_pkg::*;

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] timing_reg;
    logic [7:0] setup_reg;
    logic [31:0] rel_cnt_reg;
    logic [31:0] atk_cnt_reg;
    logic [31:0] rel_limit;
    logic [31:0] atk_limit;
    logic [31:0] rel_base;
    logic [31:0] atk_base;
    logic [7:0] rdata_next;
    logic wr_mode;
    logic wr_timing;
    logic wr_setup;
    logic wr_errclr;

    // ----------------------------------------
    // reset images
    // ----------------------------------------
    // field defaults are sliced from the register defaults so they agree
    localparam logic [7:0] MODE_RST = `AMCR_RST_MODE;
    localparam logic [7:0] TIMING_RST = `AMCR_RST_TIMING;
    localparam logic [7:0] SETUP_RST = `AMCR_RST_SETUP;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    assign wr_mode = i_wr_en && i_addr == `AMCR_OFF_MODE;
    assign wr_timing = i_wr_en && i_addr == `AMCR_OFF_TIMING;
    assign wr_setup = i_wr_en && i_addr == `AMCR_OFF_SETUP;
    // error clear holds no storage, any data value counts
    assign wr_errclr = i_wr_en && i_addr == `AMCR_OFF_ERRCLR;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            mode_reg <= `AMCR_RST_MODE;
        end
        else if (wr_mode)
        begin
            mode_reg <= i_wdata & `AMCR_MASK_MODE; // RULE_14
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            timing_reg <= `AMCR_RST_TIMING; // RULE_05
        end
        else if (wr_timing)
        begin
            timing_reg <= i_wdata & `AMCR_MASK_TIMING; // RULE_14
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            setup_reg <= `AMCR_RST_SETUP; // RULE_10
        end
        else if (wr_setup)
        begin
            setup_reg <= i_wdata;
        end
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    // unmapped offsets read zero; the gain block owns its own readback
    always_comb
    begin
        case (i_addr)
            `AMCR_OFF_MODE: rdata_next = mode_reg;
            `AMCR_OFF_TIMING: rdata_next = timing_reg;
            `AMCR_OFF_SETUP: rdata_next = setup_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_rdata <= 8'h00;
        end
        else
        begin
            // data idles at zero so a stray sample never looks valid
            o_rdata <= i_rd_en ? rdata_next : 8'h00;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_rd_en;
        end
    end

    // ----------------------------------------
    // field outputs
    // ----------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_edge_select <= amcr_edge_t'(MODE_RST[`AMCR_EDGE_LSB +: 2]);
            o_slow_edges <= MODE_RST[`AMCR_EDGE_LSB +: 2] != 2'h0;
        end
        else
        begin
            o_edge_select <= amcr_edge_t'(mode_reg[`AMCR_EDGE_LSB +: 2]);
            // supply advice for codes 10/11 is the board's concern
            o_slow_edges <= mode_reg[`AMCR_EDGE_LSB +: 2] != 2'h0; // RULE_01
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_overcurrent_auto_retry <= MODE_RST[`AMCR_OC_BIT];
            o_overheat_auto_retry <= MODE_RST[`AMCR_OT_BIT];
        end
        else
        begin
            o_overcurrent_auto_retry <= mode_reg[`AMCR_OC_BIT]; // RULE_02
            o_overheat_auto_retry <= mode_reg[`AMCR_OT_BIT]; // RULE_02
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_right_to_both_mix <= MODE_RST[`AMCR_R2B_BIT];
            o_left_to_both_mix <= MODE_RST[`AMCR_L2B_BIT];
        end
        else
        begin
            o_right_to_both_mix <= mode_reg[`AMCR_R2B_BIT]; // RULE_03
            o_left_to_both_mix <= mode_reg[`AMCR_L2B_BIT]; // RULE_04
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_release_rate_select <= TIMING_RST[`AMCR_REL_LSB +: 3];
            o_attack_rate_select <= TIMING_RST[`AMCR_ATK_LSB +: 3];
        end
        else
        begin
            o_release_rate_select <= timing_reg[`AMCR_REL_LSB +: 3]; // RULE_05
            o_attack_rate_select <= timing_reg[`AMCR_ATK_LSB +: 3]; // RULE_06
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_auto_level_enable <= SETUP_RST[`AMCR_ALC_BIT];
            o_compressor_select <=
                amcr_comp_t'(SETUP_RST[`AMCR_COMP_LSB +: 2]);
            o_threshold_basis_select <= SETUP_RST[`AMCR_BASIS_BIT];
            o_level_threshold_code <= SETUP_RST[`AMCR_LVL_LSB +: 4];
        end
        else
        begin
            o_auto_level_enable <= setup_reg[`AMCR_ALC_BIT]; // RULE_07
            o_compressor_select <=
                amcr_comp_t'(setup_reg[`AMCR_COMP_LSB +: 2]); // RULE_08
            o_threshold_basis_select <= setup_reg[`AMCR_BASIS_BIT]; // RULE_09
            // code passed straight through, analog ladder is monotonic
            o_level_threshold_code <= setup_reg[`AMCR_LVL_LSB +: 4]; // RULE_12
        end
    end

    // the gain block itself lives elsewhere; it drops writes while low
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_gain_write_allow <= ~SETUP_RST[`AMCR_ALC_BIT];
        end
        else
        begin
            o_gain_write_allow <= ~setup_reg[`AMCR_ALC_BIT]; // RULE_11
        end
    end

    // ----------------------------------------
    // error clear strobe
    // ----------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_error_clear <= 1'b0;
        end
        else
        begin
            o_error_clear <= wr_errclr; // RULE_13
        end
    end

    // ----------------------------------------
    // step timers
    // ----------------------------------------
    // base counts are parameters so simulation can shrink them
    // bases of 2**25 cycles or more overflow the limit at code 111
    assign rel_base = 32'(REL_BASE_CYC);
    assign atk_base = 32'(ATK_BASE_CYC);
    assign rel_limit = rel_base << timing_reg[`AMCR_REL_LSB +: 3]; // RULE_05
    assign atk_limit = atk_base << timing_reg[`AMCR_ATK_LSB +: 3]; // RULE_06

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst || !setup_reg[`AMCR_ALC_BIT])
        begin
            rel_cnt_reg <= 32'h0;
            o_release_step <= 1'b0;
        end
        else if (rel_cnt_reg >= rel_limit - 32'h1)
        begin
            rel_cnt_reg <= 32'h0;
            o_release_step <= 1'b1;
        end
        else
        begin
            rel_cnt_reg <= rel_cnt_reg + 32'h1;
            o_release_step <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst || !setup_reg[`AMCR_ALC_BIT])
        begin
            atk_cnt_reg <= 32'h0;
            o_attack_step <= 1'b0;
        end
        else if (atk_cnt_reg >= atk_limit - 32'h1)
        begin
            atk_cnt_reg <= 32'h0;
            o_attack_step <= 1'b1;
        end
        else
        begin
            atk_cnt_reg <= atk_cnt_reg + 32'h1;
            o_attack_step <= 1'b0;
        end
    end
endmodule // amcr_mode_level_regs

// *** test/amcr_monitor.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// port checks
// ----------------------------------------
module amcr_monitor
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_wr_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire amcr_pkg::amcr_edge_t o_edge_select,
    input wire logic o_slow_edges,
    input wire logic o_auto_level_enable,
    input wire logic o_gain_write_allow,
    input wire logic o_error_clear,
    input wire logic o_attack_step,
    input wire logic o_release_step
);
    import amcr_pkg::*;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    chk_clear_pulse: assert property (
        i_wr_en && i_addr == 8'h07 |=> o_error_clear)
        else $error("error clear pulse missing");
    chk_no_stray_clear: assert property (
        o_error_clear |-> $past(i_wr_en && i_addr == 8'h07))
        else $error("error clear without write");
    chk_slow_edge_flag: assert property (
        o_slow_edges == (o_edge_select != AMCR_EDGE_NORMAL))
        else $error("slow edge flag wrong");
    chk_gain_block: assert property (
        o_gain_write_allow == !o_auto_level_enable)
        else $error("gain write allow wrong");
    chk_steps_idle: assert property (
        !o_auto_level_enable && !$past(o_auto_level_enable)
        |-> !o_attack_step && !o_release_step)
        else $error("step pulse with level control off");
    chk_upper_bits_zero: assert property (
        o_rvalid && $past(i_addr == 8'h02 || i_addr == 8'h03)
        |-> o_rdata[7:6] == 2'b00)
        else $error("upper bits not zero");
    chk_attack_gap: assert property (
        o_attack_step |=> !o_attack_step [*8])
        else $error("attack steps too close");
    chk_enable_cause: assert property (
        $rose(o_auto_level_enable)
        |-> $past(i_wr_en && i_addr == 8'h04 && i_wdata[7], 2))
        else $error("level control enabled without write");
endmodule // amcr_monitor

// *** test/amcr_host.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// host front end model
// ----------------------------------------
module amcr_host
(
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_wr_en = 1'b0,
    output logic o_rd_en = 1'b0,
    output logic [7:0] o_addr = 8'h00,
    output logic [7:0] o_wdata = 8'h00
);
    // released lines invert so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        #1 o_wr_en = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(posedge i_ref_clk);
        #1 o_wr_en = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [8:0] r);
        @(posedge i_ref_clk);
        #1 o_rd_en = 1'b1;
        o_addr = a;
        @(posedge i_ref_clk);
        #1 o_rd_en = 1'b0;
        o_addr = ~a;
        r = {i_rvalid, i_rdata};
    endtask
endmodule // amcr_host

// *** test/amcr_mode_level_regs_tb.sv ***
`timescale 1ns/100ps
module amcr_mode_level_regs_tb;
    import amcr_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_wr_en, i_rd_en, o_rvalid, o_slow_edges, o_auto_level_enable;
    logic o_overcurrent_auto_retry, o_overheat_auto_retry, o_error_clear;
    logic o_right_to_both_mix, o_left_to_both_mix, o_threshold_basis_select;
    logic o_gain_write_allow, o_release_step, o_attack_step;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic [8:0] r;
    logic [2:0] o_release_rate_select, o_attack_rate_select;
    logic [3:0] o_level_threshold_code;
    amcr_edge_t o_edge_select;
    amcr_comp_t o_compressor_select;
    int fails = 0, n_checks = 0, cyc = 0, gap;
    wire [19:0] flds = {o_edge_select, o_overcurrent_auto_retry,
        o_overheat_auto_retry, o_right_to_both_mix, o_left_to_both_mix,
        o_release_rate_select, o_attack_rate_select, o_auto_level_enable,
        o_compressor_select, o_threshold_basis_select,
        o_level_threshold_code};
    always #2.5 i_ref_clk = ~i_ref_clk;
    // release base shortened so doubling fits the run; attack keeps 32 us
    localparam int REL_BASE = 100;
    localparam int ATK_BASE = 6400;
    amcr_mode_level_regs #(.REL_BASE_CYC(REL_BASE)) u_dut (.*);
    amcr_host u_host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata),
        .i_rvalid(o_rvalid), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wdata(i_wdata));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [19:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", n, exp, got);
            fails++;
        end
    endtask
    // cycles from one step pulse to the next of the chosen timer
    task automatic step_gap(input bit rel, output int g);
        g = 0;
        while (!(rel ? o_release_step : o_attack_step) && g < 30000)
        begin
            @(posedge i_ref_clk);
            #1 g++;
        end
        g = 0;
        do
        begin
            @(posedge i_ref_clk);
            #1 g++;
        end
        while (!(rel ? o_release_step : o_attack_step) && g < 30000);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic do_reset();
        i_srst = 1'b1;
        repeat (6) @(posedge i_ref_clk);
        #1 i_srst = 1'b0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_defaults();
        do_reset();
        chk("fields", flds, 20'h32B4B);
        u_host.rd(8'h02, r);
        chk("mode", r, 9'h10C);
        u_host.rd(8'h03, r);
        chk("timing", r, 9'h12B);
        u_host.rd(8'h04, r);
        chk("setup", r, 9'h14B);
        u_host.rd(8'h09, r);
        chk("unmapped", r, 9'h100);
    endtask
    task automatic t_mode();
        for (int i = 0; i < 8; i++)
        begin
            d = {2'b11, i[1:0], i[2] ? 4'hA : 4'h5};
            u_host.wr(8'h02, d);
            u_host.rd(8'h02, r);
            chk("mode rd", r, {3'b100, d[5:0]});
            chk("mode out", flds[19:14], d[5:0]);
            chk("slow", o_slow_edges, i[1:0] != 2'b00);
        end
    endtask
    task automatic t_timing();
        u_host.wr(8'h03, 8'hFF);
        u_host.wr(8'h09, 8'h00);
        u_host.rd(8'h03, r);
        chk("timing rd", r, 9'h13F);
        chk("timing out", flds[13:8], 6'h3F);
    endtask
    task automatic t_setup();
        for (int i = 0; i < 16; i++)
        begin
            d = {1'b0, i[1:0], i[0], i[3:0]};
            u_host.wr(8'h04, d);
            u_host.rd(8'h04, r);
            chk("setup rd", r, {1'b1, d});
            chk("setup out", flds[7:0], d);
        end
    endtask
    task automatic t_alc();
        u_host.wr(8'h03, 8'h00);
        u_host.wr(8'h04, 8'hCB);
        repeat (2) @(posedge i_ref_clk);
        #1 chk("alc on", o_auto_level_enable, 1'b1);
        chk("gain allow", o_gain_write_allow, 1'b0);
        step_gap(1'b0, gap);
        chk("attack gap", 20'(gap), 20'(ATK_BASE));
        step_gap(1'b1, gap);
        chk("release gap", 20'(gap), 20'(REL_BASE));
        u_host.wr(8'h03, 8'h09);
        step_gap(1'b0, gap);
        chk("attack gap 1", 20'(gap), 20'(ATK_BASE * 2));
        step_gap(1'b1, gap);
        chk("release gap 1", 20'(gap), 20'(REL_BASE * 2));
        u_host.wr(8'h04, 8'h4B);
        repeat (2) @(posedge i_ref_clk);
        #1 chk("gain allow", o_gain_write_allow, 1'b1);
    endtask
    task automatic t_errclr();
        u_host.wr(8'h07, 8'h5A);
        chk("clear", o_error_clear, 1'b1);
        @(posedge i_ref_clk);
        #1 chk("clear end", o_error_clear, 1'b0);
    endtask
    initial
    begin
        t_defaults();
        t_mode();
        t_timing();
        t_setup();
        t_alc();
        t_errclr();
        t_defaults();
        finish_test();
    end
    // run is about 40000 cycles, mostly the attack gaps
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fails++;
            finish_test();
        end
    end
endmodule // amcr_mode_level_regs_tb
bind amcr_mode_level_regs amcr_monitor u_mon (.i_ref_clk(i_ref_clk),
    .i_srst(i_srst), .i_wr_en(i_wr_en), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_edge_select(o_edge_select), .o_slow_edges(o_slow_edges),
    .o_auto_level_enable(o_auto_level_enable),
    .o_gain_write_allow(o_gain_write_allow),
    .o_error_clear(o_error_clear), .o_attack_step(o_attack_step),
    .o_release_step(o_release_step));
